// ### core/pin_mux_pkg.sv
// constants, register map and per-pin tables of the pin function multiplexer
package pin_mux_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int PIN_N = 46;
  localparam int IRQ_N = 15;
  localparam int GRP_N = 22;
  localparam int PSEL_W = 6;

  // ---------------------------------------------------------------
  // register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_PHY_MODE = 32'h0008c10e;
  localparam logic [31:0] ADDR_WRITE_PROTECT = 32'h0008c11f;
  localparam int WP_ENABLE_BIT = 6;
  localparam int WP_LOCK_BIT = 7;
  localparam int PHY_MODE_BIT = 4;
  localparam int INTERRUPT_INPUT_SELECT_BIT = 6;
  localparam int ANALOG_SELECT_BIT = 7;
  localparam logic WP_ENABLE_RESET = 1'b0;
  localparam logic WP_LOCK_RESET = 1'b1;
  localparam logic PHY_MODE_RESET = 1'b0;
  localparam logic [7:0] PFS_RESET = 8'h00;
  localparam logic [PSEL_W-1:0] PSEL_HIZ = 6'h00;
  localparam logic [7:0] MASK_PSEL_ONLY = 8'h3f;
  localparam logic [7:0] MASK_PSEL_IRQ = 8'h7f;
  localparam logic [7:0] MASK_PORT4 = 8'hc0;
  localparam logic [7:0] MASK_ANALOG = 8'hff;
  localparam logic [3:0] IRQ_NONE = 4'hf;

  // ---------------------------------------------------------------
  // per-pin tables, index order:
  // p12 p13 p16 p17 p26 p27 p30 p31 p34 p40..p43 p80..p82
  // pa1..pa4 pb0..pb7 pc0 pc1 pc4..pc7 pd2..pd7 pe0 pe1 pe2 pe4 pe5 pe6
  // ---------------------------------------------------------------
  localparam logic [31:0] PIN_ADDR [PIN_N] = '{
    32'h0008c14a, 32'h0008c14b, 32'h0008c14e, 32'h0008c14f, 32'h0008c156, 32'h0008c157,
    32'h0008c158, 32'h0008c159, 32'h0008c15c, 32'h0008c160, 32'h0008c161, 32'h0008c162,
    32'h0008c163, 32'h0008c180, 32'h0008c181, 32'h0008c182, 32'h0008c191, 32'h0008c192,
    32'h0008c193, 32'h0008c194, 32'h0008c198, 32'h0008c199, 32'h0008c19a, 32'h0008c19b,
    32'h0008c19c, 32'h0008c19d, 32'h0008c19e, 32'h0008c19f, 32'h0008c1a0, 32'h0008c1a1,
    32'h0008c1a4, 32'h0008c1a5, 32'h0008c1a6, 32'h0008c1a7, 32'h0008c1aa, 32'h0008c1ab,
    32'h0008c1ac, 32'h0008c1ad, 32'h0008c1ae, 32'h0008c1af, 32'h0008c1b0, 32'h0008c1b1,
    32'h0008c1b2, 32'h0008c1b4, 32'h0008c1b5, 32'h0008c1b6};

  localparam logic [7:0] PIN_WMASK [PIN_N] = '{
    MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_ONLY, MASK_PSEL_ONLY,
    MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PORT4, MASK_PORT4, MASK_PORT4,
    MASK_PORT4, MASK_PSEL_ONLY, MASK_PSEL_ONLY, MASK_PSEL_ONLY, MASK_PSEL_IRQ, MASK_PSEL_IRQ,
    MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ,
    MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ,
    MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_PSEL_IRQ, MASK_ANALOG, MASK_ANALOG,
    MASK_ANALOG, MASK_ANALOG, MASK_ANALOG, MASK_ANALOG, MASK_ANALOG, MASK_ANALOG,
    MASK_ANALOG, MASK_ANALOG, MASK_ANALOG, MASK_ANALOG};

  localparam logic [3:0] PIN_IRQ [PIN_N] = '{
    4'h2, 4'h3, 4'h6, 4'h7, 4'hf, 4'hf, 4'h0, 4'h1, 4'h4, 4'h8, 4'h9, 4'ha,
    4'hb, 4'hf, 4'hf, 4'hf, 4'hb, 4'hf, 4'h6, 4'h5, 4'hc, 4'h4, 4'hf, 4'hf,
    4'hf, 4'hf, 4'hf, 4'hf, 4'he, 4'hc, 4'hf, 4'hf, 4'hd, 4'he, 4'h2, 4'h3,
    4'h4, 4'h5, 4'h6, 4'h7, 4'hf, 4'hf, 4'h7, 4'hf, 4'h5, 4'h6};

  // ---------------------------------------------------------------
  // function groups: 0 tmr8 1 i2c 2 usb_vbus 3 mtu2 4 sci1 5 poe 6 eth_linksta
  // 7 rmii_tx 8 sd_wp_cd 9 eth_mgmt 10 tmr_clk 11 rmii_b 12 sd_slave 13 sci11
  // 14 spi_a 15 cmp0 16 cacref 17 sd_host 18 qspi 19 sci12 20 spi_b 21 cmp_e
  // ---------------------------------------------------------------
  localparam logic [PSEL_W-1:0] GRP_CODE [GRP_N] = '{
    6'h05, 6'h0f, 6'h11, 6'h01, 6'h0a, 6'h07, 6'h11, 6'h12, 6'h1a, 6'h11, 6'h02,
    6'h12, 6'h23, 6'h24, 6'h0d, 6'h1d, 6'h07, 6'h1a, 6'h1b, 6'h0c, 6'h0d, 6'h1d};

  localparam logic [PIN_N-1:0] GRP_PINS [GRP_N] = '{
    46'h00000000000f, 46'h00000000000f, 46'h000000000004, 46'h000000000030,
    46'h000000000030, 46'h000000000140, 46'h000000000100, 46'h00000000e000,
    46'h000000006000, 46'h0000000d0000, 46'h0000000d0000, 46'h00000ff00000,
    46'h00000fc00000, 46'h00000f000000, 46'h0003f0000000, 46'h000300000000,
    46'h000200000000, 46'h00fc00000000, 46'h00fc00000000, 46'h070000000000,
    46'h3f0000000000, 46'h240000000000};

endpackage

// ### core/multiplexed_pin_function_select.sv
// register-controlled pin function multiplexer with write protection
// Functional notes
// - registers of pins absent from the map read zero and ignore writes.
// - function control registers take writes only while write enable bit is one.
// - write enable bit changes only while the lock bit is zero.
// - reserved bits read zero and are not stored.
// - select bits 5..0 choose the peripheral; zero leaves the pin high impedance.
// - bit 6 routes the pin onto its external interrupt input.
// - ports 4, D and E use bit 7 to mark the pin analog.
// - port 4 has no select field, only interrupt and analog bits.
// - ports 2 and 8 have only the select field.
// - port 1 codes connect 8-bit timer, I2C and USB bus-power sense.
// - port 2 codes connect timer channel 2 and serial channel 1.
// - port 3 codes connect output-enable inputs and Ethernet link status.
// - port 8 codes connect RMII transmit and SD write-protect/card-detect.
// - port A codes connect Ethernet management and timer clock inputs.
// - port B codes connect RMII, SD slave and serial channel 11.
// - port C codes connect SPI A, compare timer 0 and clock reference.
// - port D codes connect SD host and quad SPI lines.
// - port E codes connect serial channel 12, SPI B and compare timers.
// - Ethernet control bit 4 selects channel 0 PHY mode, zero is RMII.
// - each interrupt-capable pin feeds one fixed external interrupt line.
// - after reset every pin is a plain input with all selects cleared.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module multiplexed_pin_function_select
  import pin_mux_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [PIN_N-1:0] pin_in,
  output logic [PIN_N*PSEL_W-1:0] pin_function_sel,
  output logic [PIN_N-1:0] pin_periph_connected,
  output logic [PIN_N-1:0] interrupt_input_select,
  output logic [PIN_N-1:0] analog_select,
  output logic [IRQ_N-1:0] external_interrupt_line,
  output logic [GRP_N-1:0] function_group_active,
  output logic ethernet_ch0_phy_mode,
  output logic function_register_write_enable,
  output logic enable_lock_bit
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 20) begin : g_addr_check
    $error("ADDR_W too narrow for the register map");
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [PIN_N-1:0] pin_hit;
  logic wp_hit;
  logic phy_hit;

  always_comb begin
    pin_hit = '0;
    for (int i = 0; i < PIN_N; i++) begin
      pin_hit[i] = (reg_addr == ADDR_W'(PIN_ADDR[i]));
    end
  end

  assign wp_hit = (reg_addr == ADDR_W'(ADDR_WRITE_PROTECT));
  assign phy_hit = (reg_addr == ADDR_W'(ADDR_PHY_MODE));

  // ---------------------------------------------------------------
  // write protect register
  // ---------------------------------------------------------------
  logic wp_enable_q;
  logic wp_lock_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wp_lock_q <= WP_LOCK_RESET;
    end else if (reg_wr && wp_hit) begin
      wp_lock_q <= reg_wdata[WP_LOCK_BIT];
    end
  end

  // old lock value gates the enable, so one write cannot unlock and enable together
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wp_enable_q <= WP_ENABLE_RESET;
    end else if (reg_wr && wp_hit && !wp_lock_q) begin
      wp_enable_q <= reg_wdata[WP_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // pin function control registers
  // ---------------------------------------------------------------
  logic [7:0] pfs_q [PIN_N];

  // masks keep reserved bits zero per port layout
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < PIN_N; i++) begin
        pfs_q[i] <= PFS_RESET;
      end
    end else if (reg_wr && wp_enable_q) begin
      for (int i = 0; i < PIN_N; i++) begin
        if (pin_hit[i]) begin
          pfs_q[i] <= reg_wdata & PIN_WMASK[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // ethernet mode register
  // ---------------------------------------------------------------
  logic phy_mode_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      phy_mode_q <= PHY_MODE_RESET;
    end else if (reg_wr && phy_hit) begin
      phy_mode_q <= reg_wdata[PHY_MODE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < PIN_N; i++) begin
      if (pin_hit[i]) begin
        rd_mux = pfs_q[i];
      end
    end
    if (wp_hit) begin
      rd_mux = 8'h00;
      rd_mux[WP_ENABLE_BIT] = wp_enable_q;
      rd_mux[WP_LOCK_BIT] = wp_lock_q;
    end
    if (phy_hit) begin
      rd_mux = 8'h00;
      rd_mux[PHY_MODE_BIT] = phy_mode_q;
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  logic [PIN_N-1:0] pin_sync1_q;
  logic [PIN_N-1:0] pin_sync2_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_sync1_q <= '0;
      pin_sync2_q <= '0;
    end else begin
      pin_sync1_q <= pin_in;
      pin_sync2_q <= pin_sync1_q;
    end
  end

  // ---------------------------------------------------------------
  // external interrupt routing
  // ---------------------------------------------------------------
  logic [IRQ_N-1:0] irq_d;
  logic [IRQ_N-1:0] irq_q;

  // pins that share a line are ored; software should select only one of them
  always_comb begin
    irq_d = '0;
    for (int i = 0; i < PIN_N; i++) begin
      if (pfs_q[i][INTERRUPT_INPUT_SELECT_BIT] && (PIN_IRQ[i] != IRQ_NONE)) begin
        irq_d[PIN_IRQ[i]] = irq_d[PIN_IRQ[i]] | pin_sync2_q[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_q <= '0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign external_interrupt_line = irq_q;

  // ---------------------------------------------------------------
  // function group connection
  // ---------------------------------------------------------------
  logic [GRP_N-1:0] grp_d;
  logic [GRP_N-1:0] grp_q;

  always_comb begin
    grp_d = '0;
    for (int g = 0; g < GRP_N; g++) begin
      for (int i = 0; i < PIN_N; i++) begin
        if (GRP_PINS[g][i] && (pfs_q[i][PSEL_W-1:0] == GRP_CODE[g])) begin
          grp_d[g] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      grp_q <= '0;
    end else begin
      grp_q <= grp_d;
    end
  end

  assign function_group_active = grp_q;

  // ---------------------------------------------------------------
  // per-pin outputs
  // ---------------------------------------------------------------
  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    assign pin_function_sel[i*PSEL_W +: PSEL_W] = pfs_q[i][PSEL_W-1:0];
    assign pin_periph_connected[i] = (pfs_q[i][PSEL_W-1:0] != PSEL_HIZ);
    assign interrupt_input_select[i] = pfs_q[i][INTERRUPT_INPUT_SELECT_BIT];
    assign analog_select[i] = pfs_q[i][ANALOG_SELECT_BIT];
  end

  assign ethernet_ch0_phy_mode = phy_mode_q;
  assign function_register_write_enable = wp_enable_q;
  assign enable_lock_bit = wp_lock_q;

endmodule // multiplexed_pin_function_select

`default_nettype wire

// ### dv/pin_mux_asserts.sv
// concurrent checks on the ports of the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module pin_mux_asserts
  import pin_mux_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [PIN_N-1:0] pin_in,
  input wire logic [PIN_N*PSEL_W-1:0] pin_function_sel,
  input wire logic [PIN_N-1:0] pin_periph_connected,
  input wire logic [PIN_N-1:0] interrupt_input_select,
  input wire logic [PIN_N-1:0] analog_select,
  input wire logic [IRQ_N-1:0] external_interrupt_line,
  input wire logic [GRP_N-1:0] function_group_active,
  input wire logic ethernet_ch0_phy_mode,
  input wire logic function_register_write_enable,
  input wire logic enable_lock_bit
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic wp_wr = reg_wr && reg_addr == ADDR_W'(ADDR_WRITE_PROTECT);
  wire logic phy_wr = reg_wr && reg_addr == ADDR_W'(ADDR_PHY_MODE);
  wire logic p12_wr = reg_wr && reg_addr == ADDR_W'(PIN_ADDR[0]);
  property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
  property p_lock_keeps; wp_wr && enable_lock_bit |=> $stable(function_register_write_enable); endproperty
  a_lock_keeps: assert property (p_lock_keeps) else $error("enable changed while locked");
  property p_enable_store;
    wp_wr && !enable_lock_bit |=> function_register_write_enable == $past(reg_wdata[WP_ENABLE_BIT]);
  endproperty
  a_enable_store: assert property (p_enable_store) else $error("enable not stored while unlocked");
  property p_lock_store; wp_wr |=> enable_lock_bit == $past(reg_wdata[WP_LOCK_BIT]); endproperty
  a_lock_store: assert property (p_lock_store) else $error("lock bit not stored");
  property p_blocked; p12_wr && !function_register_write_enable |=> $stable(pin_function_sel[5:0]); endproperty
  a_blocked: assert property (p_blocked) else $error("protected pin register changed");
  property p_hiz;
    {pin_periph_connected[0], pin_periph_connected[40]} == {|pin_function_sel[5:0], |pin_function_sel[245:240]};
  endproperty
  a_hiz: assert property (p_hiz) else $error("connect flag disagrees with select");
  property p_port4; pin_function_sel[77:54] == 24'h000000; endproperty
  a_port4: assert property (p_port4) else $error("port 4 select not zero");
  property p_port28; (interrupt_input_select[15:13] | interrupt_input_select[5:4]) == 5'h00; endproperty
  a_port28: assert property (p_port28) else $error("interrupt select on port 2 or 8");
  property p_analog; (analog_select[33:0] & ~34'h000001e00) == 34'h000000000; endproperty
  a_analog: assert property (p_analog) else $error("analog select on digital port");
  property p_phy; phy_wr |=> ethernet_ch0_phy_mode == $past(reg_wdata[PHY_MODE_BIT]); endproperty
  a_phy: assert property (p_phy) else $error("phy mode not stored");
  property p_irq_off; (interrupt_input_select == '0) [*2] |-> external_interrupt_line == '0; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt line active with no select");
  property p_usb_grp; 1'b1 |=> function_group_active[2] == $past(pin_function_sel[17:12] == 6'h11); endproperty
  a_usb_grp: assert property (p_usb_grp) else $error("bus power group wrong");
  c_unlock: cover property ($rose(function_register_write_enable));
  c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
  c_irq: cover property (external_interrupt_line != '0);
endmodule // pin_mux_asserts
bind multiplexed_pin_function_select pin_mux_asserts #(.ADDR_W(ADDR_W)) u_chk (.core_clk, .rst_b,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_function_sel, .pin_periph_connected,
  .interrupt_input_select, .analog_select, .external_interrupt_line, .function_group_active,
  .ethernet_ch0_phy_mode, .function_register_write_enable, .enable_lock_bit);
`default_nettype wire

// ### dv/tb_top.sv
// self-checking testbench of the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pin_mux_pkg::*;
  logic core_clk, rst_b, reg_wr, reg_rd, ethernet_ch0_phy_mode, function_register_write_enable, enable_lock_bit;
  logic [31:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [PIN_N-1:0] pin_in, pin_periph_connected, interrupt_input_select, analog_select;
  logic [PIN_N*PSEL_W-1:0] pin_function_sel;
  logic [IRQ_N-1:0] external_interrupt_line;
  logic [GRP_N-1:0] function_group_active;
  int err_count, checks, p;
  int mpin [4] = '{0, 4, 9, 34};
  logic [7:0] mexp [4] = '{8'h7f, 8'h3f, 8'hc0, 8'hff};
  multiplexed_pin_function_select #(.ADDR_W(32)) uut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pin_in, .pin_function_sel, .pin_periph_connected, .interrupt_input_select,
    .analog_select, .external_interrupt_line, .function_group_active, .ethernet_ch0_phy_mode,
    .function_register_write_enable, .enable_lock_bit);
  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  // wide enough for the concatenated flag checks, which reach 114 bits
  task automatic chk(input string what, input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rchk(input string what, input logic [31:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_reset();
    rchk("protect", ADDR_WRITE_PROTECT, 8'h80);
    rchk("phy", ADDR_PHY_MODE, 8'h00);
    for (int i = 0; i < PIN_N; i++) rchk("pin", PIN_ADDR[i], 8'h00);
    chk("sel", {interrupt_input_select, analog_select, function_group_active}, '0);
    $display("done reset values");
  endtask
  task automatic t_protect();
    wr(PIN_ADDR[0], 8'h45);
    rchk("locked pin", PIN_ADDR[0], 8'h00);
    wr(ADDR_WRITE_PROTECT, 8'h40);
    rchk("lock only", ADDR_WRITE_PROTECT, 8'h00);
    wr(ADDR_WRITE_PROTECT, 8'h40);
    rchk("unlocked", ADDR_WRITE_PROTECT, 8'h40);
    chk("enable", {enable_lock_bit, function_register_write_enable}, 2'b01);
    wr(ADDR_WRITE_PROTECT, 8'hc0);
    wr(ADDR_WRITE_PROTECT, 8'h80);
    rchk("held", ADDR_WRITE_PROTECT, 8'hc0);
    $display("done protect");
  endtask
  task automatic t_masks();
    for (int i = 0; i < 4; i++) begin
      wr(PIN_ADDR[mpin[i]], 8'hff);
      rchk("mask", PIN_ADDR[mpin[i]], mexp[i]);
      chk("fields", {analog_select[mpin[i]], interrupt_input_select[mpin[i]], pin_function_sel[mpin[i]*6+:6]},
        mexp[i]);
      wr(PIN_ADDR[mpin[i]], 8'h00);
    end
    wr(32'h0008c1b7, 8'hff);
    rchk("absent", 32'h0008c1b7, 8'h00);
    wr(ADDR_PHY_MODE, 8'hff);
    rchk("phy", ADDR_PHY_MODE, 8'h10);
    chk("phy out", ethernet_ch0_phy_mode, 1'b1);
    wr(ADDR_PHY_MODE, 8'h00);
    #1 chk("phy out", ethernet_ch0_phy_mode, 1'b0);
    $display("done masks");
  endtask
  task automatic t_groups();
    for (int g = 0; g < GRP_N; g++) begin
      p = 0;
      while (!GRP_PINS[g][p]) p++;
      wr(PIN_ADDR[p], {2'b00, GRP_CODE[g]});
      @(posedge core_clk);
      #1 chk("group", {function_group_active[g], pin_periph_connected[p]}, 2'b11);
      wr(PIN_ADDR[p], 8'h00);
    end
    @(posedge core_clk);
    #1 chk("groups idle", {function_group_active, pin_periph_connected}, '0);
    $display("done groups");
  endtask
  task automatic t_irq();
    wr(PIN_ADDR[0], 8'h40);
    pin_in <= 46'h1;
    repeat (4) @(posedge core_clk);
    #1 chk("irq on", external_interrupt_line, 15'h0004);
    wr(PIN_ADDR[0], 8'h00);
    @(posedge core_clk);
    #1 chk("irq off", external_interrupt_line, 15'h0000);
    @(posedge core_clk) pin_in <= '0;
    wr(ADDR_WRITE_PROTECT, 8'h00);
    wr(ADDR_WRITE_PROTECT, 8'h00);
    wr(PIN_ADDR[1], 8'h05);
    rchk("relocked", PIN_ADDR[1], 8'h00);
    $display("done irq and relock");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, pin_in} = '0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_protect();
    t_masks();
    t_groups();
    t_irq();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
